// File: hw/crs_core_regs.sv
// programming-model registers, stack pointer and context save sequencer
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module crs_core_regs
  import crs_pkg::*;
(
  input  wire logic                    clk_sys,     // core clock
  input  wire logic                    rst_b,       // async reset, active low
  input  wire logic [7:0]              memData,     // program memory read data
  output logic      [15:0]             memAddr,     // vector fetch address
  output logic                         memRd,       // vector fetch strobe
  input  wire logic                    aWr,         // load accumulator
  input  wire logic                    xWr,         // load first index
  input  wire logic                    yWr,         // load second index
  input  wire logic [7:0]              wrData,      // register load data
  input  wire logic                    pcLoad,      // load program counter
  input  wire logic [15:0]             pcData,      // new program counter
  input  wire logic                    pcInc,       // step program counter
  input  wire logic                    ccWr,        // load flag register
  input  wire logic                    spReinit,    // stack pointer reinit
  input  wire logic                    callReq,     // push return address
  input  wire logic                    retReq,      // pop return address
  input  wire logic                    pushReq,     // push one data byte
  input  wire logic                    popReq,      // pop one data byte into popData
  input  wire logic [CRS_NUM_IRQ-1:0]  irqReq,      // interrupt request pulses
  input  wire logic                    trapReq,     // software trap
  input  wire logic                    iretReq,     // return from interrupt
  input  wire crs_aluop_e              aluOp,       // alu operation for flags
  input  wire logic [8:0]              aluSum,      // result with carry in bit 8
  input  wire logic                    aluHalf,     // carry from bit 3 into 4
  output logic      [7:0]              acc,         // accumulator
  output logic      [7:0]              idxX,        // first index register
  output logic      [7:0]              idxY,        // second index register
  output logic      [15:0]             progCnt,     // program counter
  output logic      [15:0]             stackPtr,    // stack pointer
  output logic      [4:0]              flagReg,     // flag register
  output logic      [7:0]              popData,     // last popped byte
  output logic                         busy,        // sequencer running
  output logic      [CRS_NUM_IRQ-1:0]  irqPending   // latched requests
);
  crs_state_e  state_r;
  logic [5:0]  spLow_r;
  logic [13:0] pc_r;
  logic [7:0]  acc_r;
  logic [7:0]  x_r;
  logic [7:0]  y_r;
  logic [4:0]  cc_r;
  logic [2:0]  cnt_r;
  logic [2:0]  len_r;
  logic        isIrq_r;
  logic        rdWait_r;
  logic [7:0]  pcHiTmp_r;
  logic [7:0]  popData_r;
  logic [CRS_NUM_IRQ-1:0] pend_r;
  logic [5:0]  ramAddr;
  logic        ramWr;
  logic [7:0]  ramWrData;
  logic [7:0]  ramRd;
  logic        irqTake;
  logic        stepPush;
  logic        stepPop;
  logic [CRS_NUM_IRQ-1:0] takeOne;

  assign progCnt  = {2'b00, pc_r};
  assign stackPtr = {CRS_SP_UPPER, spLow_r};
  assign acc      = acc_r;
  assign idxX     = x_r;
  assign idxY     = y_r;
  assign flagReg  = cc_r;
  assign popData  = popData_r;
  assign irqPending = pend_r;
  assign busy     = (state_r != CRS_IDLE);
  assign memRd    = (state_r == CRS_VEC_HI) || (state_r == CRS_VEC_LO);
  assign memAddr  = (state_r == CRS_VEC_LO) ? CRS_VEC_LO_ADDR : CRS_VEC_HI_ADDR;

  // lowest pending source wins
  assign takeOne = pend_r & ~(pend_r - 1'b1);
  assign irqTake = (state_r == CRS_IDLE) && ((|pend_r && !cc_r[CRS_CC_I_BIT]) || trapReq);
  assign stepPush = (state_r == CRS_PUSH) || (state_r == CRS_TRAP)
                    || ((state_r == CRS_IDLE) && pushReq);
  assign stepPop  = (state_r == CRS_POP) && !rdWait_r;

  // push order: pc low, pc high, x, a, cc; popped in reverse
  always_comb begin
    ramWrData = 8'h00;
    if (state_r == CRS_IDLE) begin
      ramWrData = wrData;
    end else if (isIrq_r) begin
      case (cnt_r)
        3'h0:    ramWrData = pc_r[7:0];
        3'h1:    ramWrData = {2'b00, pc_r[13:8]};
        3'h2:    ramWrData = x_r;
        3'h3:    ramWrData = acc_r;
        default: ramWrData = {3'b000, cc_r};
      endcase
    end else begin
      ramWrData = (cnt_r == 3'h0) ? pc_r[7:0] : {2'b00, pc_r[13:8]};
    end
  end

  assign ramWr   = stepPush;
  // a pop reads the byte above the free slot
  assign ramAddr = (state_r == CRS_POP) ? spLow_r + 6'h01 : spLow_r;

  crs_stack_ram u_ram (
    .clk_sys (clk_sys),
    .wrEn    (ramWr),
    .addr    (ramAddr),
    .wrData  (ramWrData),
    .rdData  (ramRd)
  );

  // stack pointer stepping; 6-bit arithmetic wraps inside the page
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      spLow_r <= CRS_SP_TOP;
    end else if (state_r == CRS_IDLE && spReinit) begin
      spLow_r <= CRS_SP_TOP;
    end else if (stepPush) begin
      spLow_r <= spLow_r - 6'h01;
    end else if (stepPop || (state_r == CRS_IDLE && popReq)) begin
      if (state_r == CRS_POP) begin
        spLow_r <= spLow_r + 6'h01;
      end
    end
  end

  // sequencer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r  <= CRS_VEC_HI;
      cnt_r    <= 3'h0;
      len_r    <= 3'h0;
      isIrq_r  <= 1'b0;
      rdWait_r <= 1'b0;
    end else begin
      case (state_r)
        CRS_VEC_HI: begin
          state_r <= CRS_VEC_LO;
        end
        CRS_VEC_LO: begin
          state_r <= CRS_IDLE;
        end
        CRS_IDLE: begin
          cnt_r    <= 3'h0;
          rdWait_r <= 1'b1;
          if (irqTake) begin
            state_r <= CRS_TRAP;
            isIrq_r <= 1'b1;
            len_r   <= CRS_IRQ_BYTES;
          end else if (callReq) begin
            state_r <= CRS_PUSH;
            isIrq_r <= 1'b0;
            len_r   <= CRS_CALL_BYTES;
          end else if (iretReq) begin
            state_r <= CRS_POP;
            isIrq_r <= 1'b1;
            len_r   <= CRS_IRQ_BYTES;
          end else if (retReq || popReq) begin
            state_r <= CRS_POP;
            isIrq_r <= 1'b0;
            len_r   <= retReq ? CRS_CALL_BYTES : 3'h1;
          end
        end
        CRS_PUSH, CRS_TRAP: begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == len_r - 3'h1) begin
            state_r <= CRS_IDLE;
          end
        end
        CRS_POP: begin
          rdWait_r <= ~rdWait_r;
          if (!rdWait_r) begin
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == len_r - 3'h1) begin
              state_r <= CRS_IDLE;
            end
          end
        end
        default: state_r <= CRS_IDLE;
      endcase
    end
  end

  // pending requests: set wins over the clear on service
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~((irqTake && !trapReq) ? takeOne : '0)) | irqReq;
    end
  end

  // program counter
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pc_r      <= 14'h0000;
      pcHiTmp_r <= 8'h00;
    end else if (state_r == CRS_VEC_HI) begin
      pcHiTmp_r <= memData;
    end else if (state_r == CRS_VEC_LO) begin
      pc_r <= {pcHiTmp_r[5:0], memData};
    end else if (stepPop) begin
      // pops come back reversed: flags, a, x, pc high, pc low
      if (isIrq_r ? (cnt_r == 3'h3) : (len_r == CRS_CALL_BYTES && cnt_r == 3'h0)) begin
        pc_r[13:8] <= ramRd[5:0];
      end else if (isIrq_r ? (cnt_r == 3'h4) : (len_r == CRS_CALL_BYTES)) begin
        pc_r[7:0] <= ramRd;
      end
    end else if (state_r == CRS_IDLE && pcLoad) begin
      pc_r <= pcData[13:0];
    end else if (state_r == CRS_IDLE && pcInc) begin
      pc_r <= pc_r + 14'h0001;
    end
  end

  // data registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acc_r     <= 8'h00;
      x_r       <= 8'h00;
      y_r       <= 8'h00;
      popData_r <= 8'h00;
    end else begin
      if (stepPop) begin
        popData_r <= ramRd;
      end
      if (stepPop && isIrq_r && cnt_r == 3'h1) begin
        acc_r <= ramRd;
      end else if (aWr) begin
        acc_r <= wrData;
      end
      if (stepPop && isIrq_r && cnt_r == 3'h2) begin
        x_r <= ramRd;
      end else if (xWr) begin
        x_r <= wrData;
      end
      if (yWr) begin
        y_r <= wrData;
      end
    end
  end

  // flag register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cc_r <= CRS_CC_RESET;
    end else if (stepPop && isIrq_r && cnt_r == 3'h0) begin
      cc_r <= ramRd[4:0];
    end else if (state_r == CRS_TRAP && cnt_r == CRS_IRQ_BYTES - 3'h1) begin
      cc_r[CRS_CC_I_BIT] <= 1'b1;
    end else if (ccWr) begin
      cc_r <= wrData[4:0];
    end else if (aluOp != CRS_OP_NONE) begin
      if (aluOp == CRS_OP_ADD || aluOp == CRS_OP_SUB) begin
        cc_r[CRS_CC_H_BIT] <= aluHalf;
      end
      if (aluOp != CRS_OP_BTST) begin
        cc_r[CRS_CC_N_BIT] <= aluSum[7];
        cc_r[CRS_CC_Z_BIT] <= (aluSum[7:0] == 8'h00);
      end
      if (aluOp != CRS_OP_LOGIC) begin
        cc_r[CRS_CC_C_BIT] <= aluSum[8];
      end
    end
  end

  chk_push_dec: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_r == CRS_PUSH) |=> spLow_r == $past(spLow_r) - 6'h01)
    else $error("stack pointer did not step down after push");
  chk_pc_upper: assert property (@(posedge clk_sys) disable iff (!rst_b)
    progCnt[15:14] == 2'b00)
    else $error("program counter upper bits not zero");
  chk_sp_page: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stackPtr >= CRS_STACK_LOW && stackPtr <= CRS_SP_RESET)
    else $error("stack pointer left its page");
  chk_irq_five: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_r == CRS_IDLE && irqTake) |=> (state_r == CRS_TRAP)[*5] ##1 state_r == CRS_IDLE)
    else $error("interrupt entry not five bytes");
  chk_irq_sp: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_r == CRS_IDLE && irqTake) |=> ##5 spLow_r == $past(spLow_r, 6) - 6'h05)
    else $error("interrupt entry moved pointer wrongly");
  chk_mask_block: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_r == CRS_IDLE && cc_r[CRS_CC_I_BIT] && !trapReq) |=> state_r != CRS_TRAP)
    else $error("masked interrupt taken");
  chk_reinit_top: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_r == CRS_IDLE && spReinit && !pushReq) |=> stackPtr == CRS_SP_RESET)
    else $error("reinit did not load top of stack");
  chk_wrap_top: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (stepPush && spLow_r == 6'h00 && !(state_r == CRS_IDLE && spReinit)) |=> spLow_r == CRS_SP_TOP)
    else $error("push below bottom did not wrap");
  chk_zero_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_r == CRS_IDLE && !ccWr && aluOp == CRS_OP_ADD && !irqTake && !iretReq)
    |=> cc_r[CRS_CC_Z_BIT] == ($past(aluSum[7:0]) == 8'h00))
    else $error("zero flag wrong after add");

  // context save, restore, pointer stepping, request latching and reset vector load
  chk_pop_inc: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stepPop |=> spLow_r == $past(spLow_r) + 6'h01)
    else $error("stack pointer did not step up after pop");
  chk_idle_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_r == CRS_IDLE && !pushReq && !spReinit) |=> $stable(spLow_r))
    else $error("stack pointer moved without a stack access");
  chk_call_two: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_r == CRS_IDLE && !irqTake && callReq)
    |=> (state_r == CRS_PUSH)[*2] ##1 state_r == CRS_IDLE)
    else $error("call did not take two stack bytes");
  chk_iret_len: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_r == CRS_IDLE && !irqTake && !callReq && iretReq)
    |=> state_r == CRS_POP && len_r == CRS_IRQ_BYTES)
    else $error("return from interrupt not five bytes");
  chk_iret_end: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (stepPop && isIrq_r && cnt_r == 3'h4) |=> state_r == CRS_IDLE)
    else $error("context restore did not end after five bytes");
  chk_trap_taken: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_r == CRS_IDLE && trapReq) |=> state_r == CRS_TRAP)
    else $error("software trap not taken");
  chk_entry_mask: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_r == CRS_TRAP && cnt_r == 3'h4) |=> cc_r[CRS_CC_I_BIT])
    else $error("interrupt entry did not set the mask");
  chk_pend_latch: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (|irqReq) |=> (irqPending & $past(irqReq)) == $past(irqReq))
    else $error("interrupt request not latched");
  chk_irq_first: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_r == CRS_TRAP && cnt_r == 3'h0) |-> ramWr && ramWrData == progCnt[7:0])
    else $error("first saved byte is not pc low");
  chk_y_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busy && isIrq_r && !yWr) |=> $stable(y_r))
    else $error("second index changed by context save");
  chk_vec_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_r == CRS_VEC_LO) |=> progCnt == {2'b00, $past(pcHiTmp_r[5:0]), $past(memData)})
    else $error("reset vector not loaded into pc");
endmodule

// File: hw/crs_pkg.sv
// constants for the cpu register and stack model
package crs_pkg;
  localparam logic [15:0] CRS_PC_MASK      = 16'h3fff;
  localparam logic [15:0] CRS_VEC_HI_ADDR  = 16'h3ffe;
  localparam logic [15:0] CRS_VEC_LO_ADDR  = 16'h3fff;
  localparam logic [9:0]  CRS_SP_UPPER     = 10'h003;
  localparam logic [5:0]  CRS_SP_TOP       = 6'h3f;
  localparam logic [15:0] CRS_SP_RESET     = 16'h00ff;
  localparam logic [15:0] CRS_STACK_LOW    = 16'h00c0;
  localparam logic [4:0]  CRS_CC_RESET     = 5'h0a;
  localparam int          CRS_CC_H_BIT     = 4;
  localparam int          CRS_CC_I_BIT     = 3;
  localparam int          CRS_CC_N_BIT     = 2;
  localparam int          CRS_CC_Z_BIT     = 1;
  localparam int          CRS_CC_C_BIT     = 0;
  localparam logic [2:0]  CRS_CALL_BYTES   = 3'h2;
  localparam logic [2:0]  CRS_IRQ_BYTES    = 3'h5;
  localparam int          CRS_NUM_IRQ      = 4;
  typedef enum {CRS_IDLE, CRS_VEC_HI, CRS_VEC_LO, CRS_PUSH, CRS_POP, CRS_TRAP} crs_state_e;
  typedef enum logic [2:0] {
    CRS_OP_NONE, CRS_OP_ADD, CRS_OP_SUB, CRS_OP_LOGIC, CRS_OP_SHIFT, CRS_OP_BTST
  } crs_aluop_e;
endpackage

// File: hw/crs_stack_ram.sv
// 64-byte stack memory with registered read data
`timescale 1ns/100ps
module crs_stack_ram (
  input  wire logic       clk_sys,  // core clock
  input  wire logic       wrEn,     // write strobe
  input  wire logic [5:0] addr,     // byte address within stack page
  input  wire logic [7:0] wrData,   // data to write
  output logic      [7:0] rdData    // registered read data
);
  logic [7:0] mem [0:63];

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[addr] <= wrData;
    end
    rdData <= mem[addr];
  end
endmodule

// File: bench/test_cpu_register_and_stack_model.sv
// self-checking bench for the cpu register and stack model
`timescale 1ns/100ps
module test_cpu_register_and_stack_model;
  import crs_pkg::*;
  localparam logic [7:0] VEC_HI = 8'hd2;
  localparam logic [7:0] VEC_LO = 8'h34;
  localparam int K_A = 0, K_X = 1, K_Y = 2, K_PC = 3, K_INC = 4, K_CC = 5, K_RSP = 6;
  localparam int K_CALL = 7, K_RET = 8, K_PUSH = 9, K_POP = 10, K_TRAP = 11, K_IRET = 12;
  localparam int K_IRQ = 13;
  logic                   clk_sys;
  logic                   rst_b;
  logic [7:0]             memData;
  logic [15:0]            memAddr;
  logic                   memRd;
  logic                   aWr, xWr, yWr, pcLoad, pcInc, ccWr, spReinit;
  logic                   callReq, retReq, pushReq, popReq, trapReq, iretReq;
  logic [7:0]             wrData;
  logic [15:0]            pcData;
  logic [CRS_NUM_IRQ-1:0] irqReq;
  crs_aluop_e             aluOp;
  logic [8:0]             aluSum;
  logic                   aluHalf;
  logic [7:0]             acc, idxX, idxY, popData;
  logic [15:0]            progCnt, stackPtr;
  logic [4:0]             flagReg;
  logic                   busy;
  logic [CRS_NUM_IRQ-1:0] irqPending;
  int                     errors;
  int                     nCompared;
  int                     i;

  // program memory answers the vector fetch in the same cycle
  assign memData = (memAddr === CRS_VEC_HI_ADDR) ? VEC_HI : VEC_LO;

  crs_core_regs dut_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .memData(memData), .memAddr(memAddr), .memRd(memRd),
    .aWr(aWr), .xWr(xWr), .yWr(yWr), .wrData(wrData), .pcLoad(pcLoad), .pcData(pcData),
    .pcInc(pcInc), .ccWr(ccWr), .spReinit(spReinit), .callReq(callReq), .retReq(retReq),
    .pushReq(pushReq), .popReq(popReq), .irqReq(irqReq), .trapReq(trapReq),
    .iretReq(iretReq), .aluOp(aluOp), .aluSum(aluSum), .aluHalf(aluHalf), .acc(acc),
    .idxX(idxX), .idxY(idxY), .progCnt(progCnt), .stackPtr(stackPtr), .flagReg(flagReg),
    .popData(popData), .busy(busy), .irqPending(irqPending)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    if (errors == 0 && nCompared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    nCompared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // waits until the sequencer is idle, bounded
  task automatic idle();
    int n;
    for (n = 0; n < 40; n++) begin
      #1;
      if (busy === 1'b0) break;
      @(posedge clk_sys);
    end
    if (n == 40) begin
      errors++;
      $display("[FAIL] busy expected 0 seen %b", busy);
      print_verdict();
    end
  endtask

  // one-cycle request pulse, then wait for completion
  task automatic pulse(input int k, input logic [15:0] d);
    @(posedge clk_sys);
    wrData <= d[7:0];
    pcData <= d;
    case (k)
      K_A: aWr <= 1'b1;
      K_X: xWr <= 1'b1;
      K_Y: yWr <= 1'b1;
      K_PC: pcLoad <= 1'b1;
      K_INC: pcInc <= 1'b1;
      K_CC: ccWr <= 1'b1;
      K_RSP: spReinit <= 1'b1;
      K_CALL: callReq <= 1'b1;
      K_RET: retReq <= 1'b1;
      K_PUSH: pushReq <= 1'b1;
      K_POP: popReq <= 1'b1;
      K_TRAP: trapReq <= 1'b1;
      K_IRET: iretReq <= 1'b1;
      default: irqReq <= d[CRS_NUM_IRQ-1:0];
    endcase
    @(posedge clk_sys);
    {aWr, xWr, yWr, pcLoad, pcInc, ccWr, spReinit} <= 7'h00;
    {callReq, retReq, pushReq, popReq, trapReq, iretReq} <= 6'h00;
    irqReq <= '0;
    idle();
  endtask

  task automatic alu(input crs_aluop_e op, input logic [8:0] s, input logic h);
    @(posedge clk_sys);
    aluOp <= op;
    aluSum <= s;
    aluHalf <= h;
    @(posedge clk_sys);
    aluOp <= CRS_OP_NONE;
    #1;
  endtask

  initial begin
    errors = 0;
    nCompared = 0;
    rst_b = 1'b0;
    {aWr, xWr, yWr, pcLoad, pcInc, ccWr, spReinit} = 7'h00;
    {callReq, retReq, pushReq, popReq, trapReq, iretReq} = 6'h00;
    irqReq = '0;
    wrData = 8'h00;
    pcData = 16'h0000;
    aluOp = CRS_OP_NONE;
    aluSum = 9'h000;
    aluHalf = 1'b0;
    @(posedge clk_sys);
    #1;
    chk("sp reset", CRS_SP_RESET, stackPtr);
    chk("cc reset", {11'h000, CRS_CC_RESET}, {11'h000, flagReg});
    @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    chk("vector addr", CRS_VEC_HI_ADDR, memAddr);
    chk("vector rd", 16'h0001, {15'h0000, memRd});
    @(posedge clk_sys);
    #1;
    chk("vector lo addr", CRS_VEC_LO_ADDR, memAddr);
    idle();
    chk("pc vector", {VEC_HI, VEC_LO} & CRS_PC_MASK, progCnt);
    pulse(K_A, 16'h00a5);
    pulse(K_X, 16'h005a);
    pulse(K_Y, 16'h00c3);
    chk("acc", 16'h00a5, {8'h00, acc});
    chk("idx x", 16'h005a, {8'h00, idxX});
    chk("idx y", 16'h00c3, {8'h00, idxY});
    pulse(K_PC, 16'hffff);
    chk("pc mask", 16'h3fff, progCnt);
    pulse(K_INC, 16'h0000);
    chk("pc wrap", 16'h0000, progCnt);
    pulse(K_PC, 16'h1234);
    alu(CRS_OP_ADD, 9'h100, 1'b1);
    chk("flags add", 16'h001b, {11'h000, flagReg});
    alu(CRS_OP_SUB, 9'h080, 1'b0);
    chk("flags sub", 16'h000c, {11'h000, flagReg});
    alu(CRS_OP_LOGIC, 9'h100, 1'b1);
    chk("flags logic", 16'h000a, {11'h000, flagReg});
    alu(CRS_OP_BTST, 9'h180, 1'b1);
    chk("flags btst", 16'h000b, {11'h000, flagReg});
    alu(CRS_OP_SHIFT, 9'h080, 1'b1);
    chk("flags shift", 16'h000c, {11'h000, flagReg});
    pulse(K_CALL, 16'h0000);
    chk("sp call", 16'h00fd, stackPtr);
    pulse(K_PC, 16'h0777);
    pulse(K_RET, 16'h0000);
    chk("pc ret", 16'h1234, progCnt);
    chk("sp ret", 16'h00ff, stackPtr);
    pulse(K_PUSH, 16'h0011);
    pulse(K_PUSH, 16'h0022);
    chk("sp push", 16'h00fd, stackPtr);
    pulse(K_POP, 16'h0000);
    chk("pop last", 16'h0022, {8'h00, popData});
    pulse(K_POP, 16'h0000);
    chk("pop first", 16'h0011, {8'h00, popData});
    chk("sp pop", 16'h00ff, stackPtr);
    for (i = 0; i < 64; i++) begin
      pulse(K_PUSH, 16'(i));
      if (i == 62) chk("sp bottom", CRS_STACK_LOW, stackPtr);
    end
    chk("sp wrap", 16'h00ff, stackPtr);
    pulse(K_PUSH, 16'h0077);
    chk("sp after wrap", 16'h00fe, stackPtr);
    pulse(K_POP, 16'h0000);
    chk("pop overwrite", 16'h0077, {8'h00, popData});
    pulse(K_PUSH, 16'h0088);
    pulse(K_RSP, 16'h0000);
    chk("sp reinit", 16'h00ff, stackPtr);
    pulse(K_CC, 16'h0008);
    for (i = 0; i < CRS_NUM_IRQ; i++) pulse(K_IRQ, 16'(1 << i));
    chk("pending masked", 16'h000f, {12'h000, irqPending});
    chk("sp masked", 16'h00ff, stackPtr);
    pulse(K_CC, 16'h0000);
    for (i = 0; i < CRS_NUM_IRQ; i++) begin
      repeat (2) @(posedge clk_sys);
      idle();
      chk("sp irq", 16'h00fa, stackPtr);
      chk("mask irq", 16'h0001, {15'h0000, flagReg[CRS_CC_I_BIT]});
      if (i == 0) begin
        pulse(K_A, 16'h0001);
        pulse(K_X, 16'h0002);
        pulse(K_Y, 16'h0003);
        pulse(K_PC, 16'h0abc);
      end
      pulse(K_IRET, 16'h0000);
      chk("sp iret", 16'h00ff, stackPtr);
      if (i == 0) begin
        chk("acc iret", 16'h00a5, {8'h00, acc});
        chk("x iret", 16'h005a, {8'h00, idxX});
        chk("y kept", 16'h0003, {8'h00, idxY});
        chk("pc iret", 16'h1234, progCnt);
        chk("cc iret", 16'h0000, {11'h000, flagReg});
      end
    end
    chk("pending done", 16'h0000, {12'h000, irqPending});
    pulse(K_CC, 16'h0008);
    pulse(K_TRAP, 16'h0000);
    chk("sp trap", 16'h00fa, stackPtr);
    pulse(K_IRET, 16'h0000);
    chk("cc trap", 16'h0008, {11'h000, flagReg});
    chk("sp trap ret", 16'h00ff, stackPtr);
    pulse(K_TRAP, 16'h0000);
    pulse(K_POP, 16'h0000);
    chk("stack cc", 16'h0008, {8'h00, popData});
    pulse(K_POP, 16'h0000);
    chk("stack acc", 16'h00a5, {8'h00, popData});
    pulse(K_POP, 16'h0000);
    chk("stack x", 16'h005a, {8'h00, popData});
    pulse(K_POP, 16'h0000);
    chk("stack pc hi", 16'h0012, {8'h00, popData});
    pulse(K_POP, 16'h0000);
    chk("stack pc lo", 16'h0034, {8'h00, popData});
    chk("sp stack read", 16'h00ff, stackPtr);
    print_verdict();
  end
endmodule
